// [verilog/bdf_ctrl.sv]
/*
  Backlight dimming and fault control core: brightness source, phased dimming, current scale,
  fault latching with open-drain interrupt, pump status, boost clock source and frequency.
  Assumes straps and analog comparators arrive already decoded and synchronous to sys_clk.
*/
// What this block does
// - Brightness follows PWM input duty by default, or a host-written value.
// - Latched faults clear by host write or on enable falling edge.
// - Each channel has a 12-bit host-written current scale.
// - Active channel pulses are spaced evenly, a period divided by string count.
// - Phase mode follows the decoded string count automatically.
// - Channels beyond string count are off, unmonitored, and raise no LED faults.
// - Faults drive an open-drain interrupt output.
// - At start-up, use external sync clock if present, else internal clock.
// - Static high sync input enables spread spectrum; static low disables it.
// - With enable low, host interface and fault detection are inactive.
// - Everything except PWM duty measurement runs while enable is high and stops when it drops.
// - With pump enabled, report whether a flying capacitor was detected.
// - Pump faults set a status flag and, if unmasked, the interrupt.
// - Pump interrupt enable gates pump faults onto the interrupt.
// - Pump is enabled only when its supply pins are not tied to supply.
// - Boost frequency comes from a fixed table chosen by decoded config.
// - Each fault kind is detected and latched as a separate flag.
// - Power-line switch is off when disabled or on a fault.
// - Host can read back faults and control brightness of all channels.
`timescale 1ns/10ps
`default_nettype none
module bdf_ctrl #(
  parameter int NUM_CH = bdf_pkg::NUM_CH,
  parameter int BRIGHT_W = bdf_pkg::BRIGHT_W,
  parameter int SYNC_DETECT_CYC = bdf_pkg::SYNC_DETECT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable_in,
  input wire logic pwm_in,
  input wire logic boost_clock_sync_in,
  input wire logic [2:0] string_count_cfg,
  input wire logic [2:0] boost_freq_cfg,
  input wire logic [BRIGHT_W-1:0] dim_freq_cfg,
  input wire logic pump_supply_pin,
  input wire logic pump_cap_sense,
  input wire bdf_pkg::bdf_host_wr_t host_wr,
  input wire bdf_pkg::bdf_fault_in_t fault_in,
  output logic [NUM_CH-1:0] led_channel_out,
  output logic [NUM_CH-1:0] channel_active,
  output logic [NUM_CH*bdf_pkg::SCALE_W-1:0] channel_current_scale,
  output logic [BRIGHT_W-1:0] brightness_r,
  output logic [bdf_pkg::NUM_FAULT-1:0] fault_flags_r,
  output logic [3*NUM_CH-1:0] led_fault_ch_r,
  output logic pump_fault_flag,
  output logic pump_cap_detected,
  output logic pump_enable,
  output logic pump_fault_irq_enable,
  output logic fault_irq_out,
  output logic fault_irq_oe_b,
  output logic host_if_active,
  output logic power_switch_on,
  output bdf_pkg::bdf_clk_src_t boost_clk_src_r,
  output logic [11:0] boost_freq_khz
);
  // ----------------------------------------------------------------
  // Enable tracking
  // ----------------------------------------------------------------
  logic en_d_r;
  logic en_fall;
  assign en_fall = en_d_r && !enable_in;
  assign host_if_active = enable_in;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      en_d_r <= 1'b0;
    else
      en_d_r <= enable_in;
  end

  // ----------------------------------------------------------------
  // Brightness source and current scale
  // ----------------------------------------------------------------
  logic sel_serial_r, sel_serial_nxt;
  logic [BRIGHT_W-1:0] host_bright_r, host_bright_nxt;
  logic [BRIGHT_W-1:0] brightness_nxt;
  logic [BRIGHT_W-1:0] period_cnt_r, period_cnt_nxt;
  logic [BRIGHT_W-1:0] pwm_high_r, pwm_high_nxt;
  logic [BRIGHT_W-1:0] pwm_cyc_r, pwm_cyc_nxt;
  logic pwm_d_r;
  logic [NUM_CH*bdf_pkg::SCALE_W-1:0] scale_r, scale_nxt;
  logic pump_irq_en_r, pump_irq_en_nxt;
  logic wr_ok;
  assign wr_ok = host_wr.wr && enable_in;

  // Measure input duty over each PWM period, rescaled to the dimming period
  always_comb
  begin
    sel_serial_nxt = sel_serial_r;
    host_bright_nxt = host_bright_r;
    scale_nxt = scale_r;
    pump_irq_en_nxt = pump_irq_en_r;
    pwm_high_nxt = pwm_high_r;
    pwm_cyc_nxt = pwm_cyc_r;
    brightness_nxt = brightness_r;
    period_cnt_nxt = (period_cnt_r >= dim_freq_cfg) ? '0 : BRIGHT_W'(period_cnt_r + 1'b1);
    if (wr_ok)
    begin
      sel_serial_nxt = host_wr.sel_serial;
      host_bright_nxt = host_wr.brightness;
      pump_irq_en_nxt = host_wr.pump_fault_irq_enable;
      if (int'(host_wr.ch) < NUM_CH)
        scale_nxt[host_wr.ch*bdf_pkg::SCALE_W +: bdf_pkg::SCALE_W] = host_wr.scale;
    end
    if (pwm_in && !pwm_d_r)
    begin
      // Rising edge closes a PWM period: high/total scaled to dimming period
      if (pwm_cyc_r != '0)
        brightness_nxt = BRIGHT_W'((32'(pwm_high_r) * 32'(dim_freq_cfg)) / 32'(pwm_cyc_r));
      // The rising sample is itself a high clock of the new period
      pwm_high_nxt = BRIGHT_W'(1);
      pwm_cyc_nxt = BRIGHT_W'(1);
    end
    else
    begin
      if (pwm_cyc_r != '1)
        pwm_cyc_nxt = BRIGHT_W'(pwm_cyc_r + 1'b1);
      if (pwm_in && pwm_high_r != '1)
        pwm_high_nxt = BRIGHT_W'(pwm_high_r + 1'b1);
    end
    if (sel_serial_r)
      brightness_nxt = host_bright_r;
    if (!enable_in)
      period_cnt_nxt = '0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_serial_r <= 1'b0;
      host_bright_r <= bdf_pkg::BRIGHT_RST;
      scale_r <= {NUM_CH{bdf_pkg::SCALE_RST}};
      pump_irq_en_r <= 1'b1;
      pwm_high_r <= '0;
      pwm_cyc_r <= '0;
      pwm_d_r <= 1'b0;
      brightness_r <= bdf_pkg::BRIGHT_RST;
      period_cnt_r <= '0;
    end
    else
    begin
      sel_serial_r <= sel_serial_nxt;
      host_bright_r <= host_bright_nxt;
      scale_r <= scale_nxt;
      pump_irq_en_r <= pump_irq_en_nxt;
      pwm_high_r <= pwm_high_nxt;
      pwm_cyc_r <= pwm_cyc_nxt;
      pwm_d_r <= pwm_in;
      brightness_r <= brightness_nxt;
      period_cnt_r <= period_cnt_nxt;
    end
  end

  assign channel_current_scale = scale_r;
  assign pump_fault_irq_enable = pump_irq_en_r;

  // ----------------------------------------------------------------
  // Phase-shifted dimming channels
  // ----------------------------------------------------------------
  logic [2:0] n_str;
  logic [BRIGHT_W-1:0] phase_step;
  assign n_str = (string_count_cfg == 3'h0) ? 3'h1 :
                 ((int'(string_count_cfg) > NUM_CH) ? 3'(NUM_CH) : string_count_cfg);
  assign phase_step = BRIGHT_W'((32'(dim_freq_cfg) + 32'd1) / 32'(n_str));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      assign channel_active[gi] = (gi < n_str);
      bdf_phase_dimmer #(.W(BRIGHT_W)) u_dim (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(enable_in && channel_active[gi]),
        .count(period_cnt_r),
        .offset(BRIGHT_W'(32'(phase_step) * gi)),
        .duty(brightness_r),
        .pulse_r(led_channel_out[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault latching
  // ----------------------------------------------------------------
  logic [bdf_pkg::NUM_FAULT-1:0] raw_f;
  logic [bdf_pkg::NUM_FAULT-1:0] flags_nxt;
  logic [3*NUM_CH-1:0] led_ch_nxt;
  logic [3*NUM_CH-1:0] led_raw;
  logic [NUM_CH-1:0] act;
  assign act = channel_active;
  assign led_raw = {fault_in.short_gnd & act, fault_in.short_led & act, fault_in.open_str & act};

  // Gather distinct fault sources; all gated off while disabled
  always_comb
  begin
    raw_f = '0;
    raw_f[bdf_pkg::F_OPEN] = |(fault_in.open_str & act);
    raw_f[bdf_pkg::F_SHORT] = |(fault_in.short_led & act);
    raw_f[bdf_pkg::F_GND] = |(fault_in.short_gnd & act);
    raw_f[bdf_pkg::F_RES] = fault_in.res_range;
    raw_f[bdf_pkg::F_BOCP] = fault_in.boost_ocp;
    raw_f[bdf_pkg::F_BOVP] = fault_in.boost_ovp;
    raw_f[bdf_pkg::F_VDD_UV] = fault_in.vdd_uv;
    raw_f[bdf_pkg::F_VIN_OV] = fault_in.vin_ov;
    raw_f[bdf_pkg::F_VIN_UV] = fault_in.vin_uv;
    raw_f[bdf_pkg::F_VIN_OC] = fault_in.vin_oc;
    raw_f[bdf_pkg::F_TSD] = fault_in.over_temp;
    raw_f[bdf_pkg::F_PUMP] = fault_in.pump_fault && pump_enable;
    if (!enable_in)
      raw_f = '0;
    flags_nxt = fault_flags_r;
    led_ch_nxt = led_fault_ch_r;
    if (wr_ok)
      flags_nxt = flags_nxt & ~host_wr.clear_mask;
    if (wr_ok && host_wr.clear_mask[bdf_pkg::F_OPEN])
      led_ch_nxt[NUM_CH-1:0] = '0;
    if (wr_ok && host_wr.clear_mask[bdf_pkg::F_SHORT])
      led_ch_nxt[2*NUM_CH-1:NUM_CH] = '0;
    if (wr_ok && host_wr.clear_mask[bdf_pkg::F_GND])
      led_ch_nxt[3*NUM_CH-1:2*NUM_CH] = '0;
    if (en_fall)
    begin
      flags_nxt = '0;
      led_ch_nxt = '0;
    end
    flags_nxt = flags_nxt | raw_f;
    led_ch_nxt = led_ch_nxt | (enable_in ? led_raw : '0);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fault_flags_r <= '0;
      led_fault_ch_r <= '0;
    end
    else
    begin
      fault_flags_r <= flags_nxt;
      led_fault_ch_r <= led_ch_nxt;
    end
  end

  // Unmasked flags hold the open-drain line low
  logic irq_any;
  assign irq_any = |(fault_flags_r & ~({{(bdf_pkg::NUM_FAULT-1){1'b0}}, !pump_irq_en_r} << bdf_pkg::F_PUMP));
  assign fault_irq_out = 1'b0;
  assign fault_irq_oe_b = !irq_any;
  assign pump_fault_flag = fault_flags_r[bdf_pkg::F_PUMP];
  assign power_switch_on = enable_in && (fault_flags_r == '0);

  // ----------------------------------------------------------------
  // Charge pump detection
  // ----------------------------------------------------------------
  assign pump_enable = enable_in && !pump_supply_pin;
  assign pump_cap_detected = pump_enable && pump_cap_sense;

  // ----------------------------------------------------------------
  // Boost clock source detection
  // ----------------------------------------------------------------
  logic [31:0] det_cnt_r, det_cnt_nxt;
  logic [3:0] edge_cnt_r, edge_cnt_nxt;
  logic sync_d_r;
  logic det_done_r, det_done_nxt;
  bdf_pkg::bdf_clk_src_t src_nxt;

  // Count sync edges for a window after enable, then lock the choice
  always_comb
  begin
    det_cnt_nxt = det_cnt_r;
    edge_cnt_nxt = edge_cnt_r;
    det_done_nxt = det_done_r;
    src_nxt = boost_clk_src_r;
    if (!enable_in)
    begin
      det_cnt_nxt = '0;
      edge_cnt_nxt = '0;
      det_done_nxt = 1'b0;
      src_nxt = bdf_pkg::CLK_INTERNAL;
    end
    else if (!det_done_r)
    begin
      if (boost_clock_sync_in != sync_d_r && edge_cnt_r != 4'hf)
        edge_cnt_nxt = 4'(edge_cnt_r + 1'b1);
      det_cnt_nxt = 32'(det_cnt_r + 1);
      if (det_cnt_r >= 32'(SYNC_DETECT_CYC - 1))
      begin
        det_done_nxt = 1'b1;
        if (edge_cnt_r >= bdf_pkg::SYNC_MIN_EDGES)
          src_nxt = bdf_pkg::CLK_EXTERNAL;
        else if (boost_clock_sync_in)
          src_nxt = bdf_pkg::CLK_SPREAD;
        else
          src_nxt = bdf_pkg::CLK_INTERNAL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      det_cnt_r <= '0;
      edge_cnt_r <= '0;
      sync_d_r <= 1'b0;
      det_done_r <= 1'b0;
      boost_clk_src_r <= bdf_pkg::CLK_INTERNAL;
    end
    else
    begin
      det_cnt_r <= det_cnt_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      sync_d_r <= boost_clock_sync_in;
      det_done_r <= det_done_nxt;
      boost_clk_src_r <= src_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Boost frequency table
  // ----------------------------------------------------------------
  always_comb
  begin
    case (boost_freq_cfg)
      3'h0: boost_freq_khz = bdf_pkg::BST_KHZ_0;
      3'h1: boost_freq_khz = bdf_pkg::BST_KHZ_1;
      3'h2: boost_freq_khz = bdf_pkg::BST_KHZ_2;
      3'h3: boost_freq_khz = bdf_pkg::BST_KHZ_3;
      3'h4: boost_freq_khz = bdf_pkg::BST_KHZ_4;
      3'h5: boost_freq_khz = bdf_pkg::BST_KHZ_5;
      3'h6: boost_freq_khz = bdf_pkg::BST_KHZ_6;
      default: boost_freq_khz = bdf_pkg::BST_KHZ_7;
    endcase
  end
endmodule : bdf_ctrl
`default_nettype wire

// [verilog/bdf_pkg.sv]
/*
  Shared constants and carrier types for the backlight dimming and fault control block.
  Assumes a single 100 MHz system clock and resistor straps decoded to small indices elsewhere.
*/
`default_nettype none
package bdf_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int SCALE_W = 12;
  localparam int BRIGHT_W = 16;
  localparam int NUM_FAULT = 12;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SYNC_DETECT_US = 20;
  localparam int SYNC_DETECT_CYC = SYNC_DETECT_US * CLK_MHZ;
  localparam logic [3:0] SYNC_MIN_EDGES = 4'h4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] SCALE_RST = 12'hfff;
  localparam logic [15:0] BRIGHT_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Fault bit positions
  // ----------------------------------------------------------------
  localparam int F_OPEN = 0;
  localparam int F_SHORT = 1;
  localparam int F_GND = 2;
  localparam int F_RES = 3;
  localparam int F_BOCP = 4;
  localparam int F_BOVP = 5;
  localparam int F_VDD_UV = 6;
  localparam int F_VIN_OV = 7;
  localparam int F_VIN_UV = 8;
  localparam int F_VIN_OC = 9;
  localparam int F_TSD = 10;
  localparam int F_PUMP = 11;
  // ----------------------------------------------------------------
  // Boost frequency table in kHz, indexed by decoded config
  // ----------------------------------------------------------------
  localparam logic [11:0] BST_KHZ_0 = 12'h190;
  localparam logic [11:0] BST_KHZ_1 = 12'h0c8;
  localparam logic [11:0] BST_KHZ_2 = 12'h12f;
  localparam logic [11:0] BST_KHZ_3 = 12'h064;
  localparam logic [11:0] BST_KHZ_4 = 12'h1f4;
  localparam logic [11:0] BST_KHZ_5 = 12'h71a;
  localparam logic [11:0] BST_KHZ_6 = 12'h7d0;
  localparam logic [11:0] BST_KHZ_7 = 12'h8ae;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLK_INTERNAL = 3'b001,
    CLK_EXTERNAL = 3'b010,
    CLK_SPREAD = 3'b100
  } bdf_clk_src_t;

  typedef struct packed {
    logic [NUM_CH-1:0] open_str;
    logic [NUM_CH-1:0] short_led;
    logic [NUM_CH-1:0] short_gnd;
    logic res_range;
    logic boost_ocp;
    logic boost_ovp;
    logic vdd_uv;
    logic vin_ov;
    logic vin_uv;
    logic vin_oc;
    logic over_temp;
    logic pump_fault;
  } bdf_fault_in_t;

  typedef struct packed {
    logic wr;
    logic sel_serial;
    logic [BRIGHT_W-1:0] brightness;
    logic [2:0] ch;
    logic [SCALE_W-1:0] scale;
    logic pump_fault_irq_enable;
    logic [NUM_FAULT-1:0] clear_mask;
  } bdf_host_wr_t;
endpackage : bdf_pkg
`default_nettype wire

// [verilog/bdf_phase_dimmer.sv]
/*
  One dimming channel: a counter wrap offset by a phase, compared against a duty.
  Assumes the period counter is shared and run by the parent.
*/
`timescale 1ns/10ps
`default_nettype none
module bdf_phase_dimmer #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] offset,
  input wire logic [W-1:0] duty,
  output logic pulse_r
);
  logic [W-1:0] local_cnt;
  logic pulse_nxt;

  // ----------------------------------------------------------------
  // Shifted compare
  // ----------------------------------------------------------------
  // Shift the shared count by this channel's phase offset
  always_comb
  begin
    local_cnt = W'(count - offset);
    pulse_nxt = run && (local_cnt < duty);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pulse_r <= 1'b0;
    else
      pulse_r <= pulse_nxt;
  end
endmodule : bdf_phase_dimmer
`default_nettype wire

// [verif/bdf_ctrl_asserts.sv]
/*
  Port checker for bdf_ctrl.
  Assumes it is bound to bdf_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module bdf_ctrl_asserts #(
  parameter int NUM_CH = 6,
  parameter int BRIGHT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable_in,
  input wire logic pump_supply_pin,
  input wire logic pump_cap_sense,
  input wire bdf_pkg::bdf_host_wr_t host_wr,
  input wire bdf_pkg::bdf_fault_in_t fault_in,
  input wire logic [NUM_CH-1:0] led_channel_out,
  input wire logic [NUM_CH-1:0] channel_active,
  input wire logic [BRIGHT_W-1:0] brightness_r,
  input wire logic [11:0] fault_flags_r,
  input wire logic pump_fault_flag,
  input wire logic pump_cap_detected,
  input wire logic pump_enable,
  input wire logic pump_fault_irq_enable,
  input wire logic fault_irq_out,
  input wire logic fault_irq_oe_b,
  input wire logic power_switch_on,
  input wire bdf_pkg::bdf_clk_src_t boost_clk_src_r
);
  // ----------------------------
  // Properties
  // ----------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Flags latch, hold and clear
  flag_set_a: assert property (enable_in && fault_in.boost_ovp |=> fault_flags_r[5])
    else $error("flag not latched");
  flag_hold_a: assert property (fault_flags_r[5] && enable_in && !host_wr.wr |=> fault_flags_r[5])
    else $error("flag dropped");
  en_clear_a: assert property ($fell(enable_in) |-> ##[1:2] fault_flags_r == 12'h000)
    else $error("flags kept after disable");
  idle_quiet_a: assert property (!enable_in && fault_flags_r == 12'h000 |=> fault_flags_r == 12'h000)
    else $error("fault seen while disabled");
  // Open-drain interrupt and power switch follow the flags
  irq_level_a: assert property (fault_irq_oe_b == !(|fault_flags_r[10:0] ||
    (pump_fault_flag && pump_fault_irq_enable)) && fault_irq_out == 1'b0)
    else $error("interrupt level wrong");
  power_sw_a: assert property (power_switch_on == (enable_in && fault_flags_r == 12'h000))
    else $error("power switch wrong");
  // Channels, pump and brightness
  lane_off_a: assert property ((led_channel_out & ~$past(channel_active)) == '0)
    else $error("inactive channel pulsed");
  pump_stat_a: assert property (pump_enable == (enable_in && !pump_supply_pin) &&
    pump_cap_detected == (pump_enable && pump_cap_sense))
    else $error("pump status wrong");
  serial_br_a: assert property (host_wr.wr && enable_in && host_wr.sel_serial ##1 enable_in
    |=> brightness_r == $past(host_wr.brightness, 2))
    else $error("serial brightness wrong");
  // Boost clock source reverts when disabled and, while enabled, holds once it is not internal
  src_revert_a: assert property (!enable_in |=> boost_clk_src_r == bdf_pkg::CLK_INTERNAL)
    else $error("source not internal");
  src_hold_a: assert property (enable_in && boost_clk_src_r != bdf_pkg::CLK_INTERNAL
    |=> $stable(boost_clk_src_r))
    else $error("source changed");
  cover property ($rose(led_channel_out[3]));
  cover property (boost_clk_src_r == bdf_pkg::CLK_SPREAD);
  cover property ($fell(fault_irq_oe_b));
endmodule : bdf_ctrl_asserts
bind bdf_ctrl bdf_ctrl_asserts #(.NUM_CH(NUM_CH), .BRIGHT_W(BRIGHT_W)) u_chk (
  .sys_clk, .rst_b, .enable_in, .pump_supply_pin, .pump_cap_sense, .host_wr, .fault_in,
  .led_channel_out, .channel_active, .brightness_r, .fault_flags_r, .pump_fault_flag,
  .pump_cap_detected, .pump_enable, .pump_fault_irq_enable, .fault_irq_out, .fault_irq_oe_b,
  .power_switch_on, .boost_clk_src_r
);
`default_nettype wire

// [verif/bdf_host_model.sv]
/*
  Host controller and PWM brightness source facing bdf_ctrl.
  Assumes the bench calls write after reset; t_enable also calls it with enable low.
*/
`timescale 1ns/10ps
`default_nettype none
module bdf_host_model #(
  parameter logic [7:0] HI = 8'h0a,
  parameter logic [7:0] PER = 8'h21
) (
  input wire logic sys_clk,
  output var logic pwm_in,
  output var bdf_pkg::bdf_host_wr_t host_wr
);
  logic [7:0] cnt_r = 8'h00;
  initial
  begin
    pwm_in = 1'b0;
    host_wr = '0;
  end
  // PWM source, high for HI of every PER clocks
  always @(negedge sys_clk)
  begin
    cnt_r <= (cnt_r == PER - 8'h01) ? 8'h00 : cnt_r + 8'h01;
    pwm_in <= (cnt_r < HI);
  end
  // One-cycle write; fields scrambled once the strobe drops
  task automatic write(input bdf_pkg::bdf_host_wr_t w);
    bdf_pkg::bdf_host_wr_t v;
    v = w;
    v.wr = 1'b1;
    @(negedge sys_clk);
    host_wr = v;
    v = ~w;
    v.wr = 1'b0;
    @(negedge sys_clk);
    host_wr = v;
  endtask : write
endmodule : bdf_host_model
`default_nettype wire

// [verif/bdf_ctrl_test.sv]
/*
  Self-checking bench for bdf_ctrl.
  Assumes the package, design, checker and host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module bdf_ctrl_test;
  logic sys_clk;
  logic rst_b;
  logic enable_in;
  logic pwm_in;
  logic sync_in;
  logic sync_run;
  logic [2:0] str_cfg;
  logic [2:0] bf_cfg;
  logic pss;
  logic cap;
  logic irq_en;
  logic oe_b;
  logic pwr_on;
  logic hif;
  logic [5:0] led;
  logic [5:0] act;
  logic [71:0] scale;
  logic [15:0] bright;
  logic [11:0] flags;
  logic [17:0] ledf;
  logic [11:0] khz;
  bdf_pkg::bdf_clk_src_t src;
  bdf_pkg::bdf_host_wr_t host_wr;
  bdf_pkg::bdf_host_wr_t hw;
  bdf_pkg::bdf_fault_in_t flt;
  int failures;
  int check_count;
  int cyc;
  bdf_ctrl #(.SYNC_DETECT_CYC(50)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .enable_in(enable_in), .pwm_in(pwm_in),
    .boost_clock_sync_in(sync_in), .string_count_cfg(str_cfg), .boost_freq_cfg(bf_cfg),
    .dim_freq_cfg(16'h0063), .pump_supply_pin(pss), .pump_cap_sense(cap), .host_wr(host_wr),
    .fault_in(flt), .led_channel_out(led), .channel_active(act), .channel_current_scale(scale),
    .brightness_r(bright), .fault_flags_r(flags), .led_fault_ch_r(ledf), .pump_fault_flag(),
    .pump_cap_detected(), .pump_enable(), .pump_fault_irq_enable(irq_en), .fault_irq_out(),
    .fault_irq_oe_b(oe_b), .host_if_active(hif), .power_switch_on(pwr_on),
    .boost_clk_src_r(src), .boost_freq_khz(khz)
  );
  bdf_host_model u_host (.sys_clk(sys_clk), .pwm_in(pwm_in), .host_wr(host_wr));
  // ----------------------------
  // Clock, sync toggler, timeout
  // ----------------------------
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
  begin
    if (sync_run)
      sync_in <= ~sync_in;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic go(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : go
  task automatic put();
    u_host.write(hw);
    hw.clear_mask = 12'h000;
  endtask : put
  // Pulse one fault input bit for a single edge
  task automatic hit(input int b);
    flt[b] = 1'b1;
    go(1);
    flt = '0;
    go(2);
  endtask : hit
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset();
    chk(scale, {6{12'hfff}}, "scale reset");
    chk({flags, oe_b, irq_en, src}, {12'h000, 2'b11, 3'b001}, "reset state");
  endtask : t_reset
  task automatic t_cfg();
    logic [11:0] tbl [8] = '{12'h190, 12'h0c8, 12'h12f, 12'h064, 12'h1f4, 12'h71a, 12'h7d0, 12'h8ae};
    for (int i = 0; i < 8; i++)
    begin
      str_cfg = 3'(i);
      bf_cfg = 3'(i);
      go(1);
      chk(act, (72'h1 << (i == 0 ? 1 : i > 6 ? 6 : i)) - 72'h1, "active");
      chk(khz, tbl[i], "boost freq");
    end
    str_cfg = 3'h4;
  endtask : t_cfg
  task automatic t_pwm();
    go(120);
    chk(bright, 16'h001e, "pwm duty");
    hw.sel_serial = 1'b1;
    hw.brightness = 16'h000a;
    put();
    go(1);
    chk({bright, hif}, {16'h000a, 1'b1}, "serial");
  endtask : t_pwm
  // Four strings, period 100: duty 10 each, rises 25 apart
  task automatic t_dim();
    int hi [6] = '{default: 0};
    int rt [6] = '{default: 0};
    logic [5:0] prev;
    prev = led;
    for (int k = 0; k < 100; k++)
    begin
      go(1);
      for (int i = 0; i < 6; i++)
      begin
        hi[i] += int'(led[i]);
        if (led[i] && !prev[i])
          rt[i] = k;
      end
      prev = led;
    end
    for (int i = 0; i < 6; i++)
      chk(72'(hi[i]), (i < 4) ? 72'h0a : 72'h00, "duty");
    for (int i = 1; i < 4; i++)
      chk(72'((rt[i] - rt[0] + 100) % 100), 72'(25 * i), "phase");
  endtask : t_dim
  task automatic t_scale();
    hw.ch = 3'h2;
    hw.scale = 12'h5a5;
    put();
    chk(scale[35:24], 12'h5a5, "scale");
    hw.ch = 3'h6;
    hw.scale = 12'h123;
    put();
    chk(scale, {36'hfff_fff_fff, 12'h5a5, 24'hfff_fff}, "scale ch6");
  endtask : t_scale
  task automatic t_fault();
    hit(26);
    chk(flags, 12'h000, "unused string");
    hit(22);
    chk({flags, ledf, oe_b, pwr_on}, {12'h001, 18'h00002, 2'b00}, "open string");
    hw.clear_mask = 12'h001;
    put();
    chk({flags, oe_b}, {12'h000, 1'b1}, "host clear");
    for (int b = 3; b < 11; b++)
    begin
      hit(11 - b);
      chk(flags, 72'h1 << b, "fault kind");
      hw.clear_mask = 12'hfff;
      put();
    end
  endtask : t_fault
  task automatic t_enable();
    hit(7);
    enable_in = 1'b0;
    go(3);
    chk(flags, 12'h000, "enable fall");
    hit(1);
    hw.ch = 3'h0;
    put();
    chk({flags, scale[11:0], hif}, {12'h000, 12'hfff, 1'b0}, "disabled");
    hw.ch = 3'h6;
    enable_in = 1'b1;
    go(1);
  endtask : t_enable
  task automatic t_pump();
    pss = 1'b0;
    cap = 1'b1;
    hw.pump_fault_irq_enable = 1'b0;
    put();
    hit(0);
    chk({flags, oe_b}, {12'h800, 1'b1}, "masked pump");
    hw.pump_fault_irq_enable = 1'b1;
    put();
    chk(oe_b, 1'b0, "unmasked pump");
    hw.clear_mask = 12'hfff;
    put();
    pss = 1'b1;
    hit(0);
    chk(flags, 12'h000, "pump off");
  endtask : t_pump
  task automatic t_src(input logic run, input logic lvl, input logic [2:0] exp);
    enable_in = 1'b0;
    sync_run = run;
    if (!run)
      sync_in = lvl;
    go(2);
    enable_in = 1'b1;
    go(60);
    chk(src, exp, "clock source");
    sync_run = 1'b0;
    go(60);
    chk(src, exp, "source held");
  endtask : t_src
  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    enable_in = 1'b0;
    sync_in = 1'b0;
    sync_run = 1'b0;
    str_cfg = 3'h4;
    bf_cfg = 3'h0;
    pss = 1'b1;
    cap = 1'b0;
    failures = 0;
    check_count = 0;
    cyc = 0;
    hw = '0;
    hw.ch = 3'h6;
    hw.pump_fault_irq_enable = 1'b1;
    flt = '0;
    go(3);
    rst_b = 1'b1;
    t_reset();
    enable_in = 1'b1;
    t_cfg();
    t_pwm();
    t_dim();
    t_scale();
    t_fault();
    t_enable();
    t_pump();
    t_src(1'b1, 1'b0, 3'b010);
    t_src(1'b0, 1'b1, 3'b100);
    t_src(1'b0, 1'b0, 3'b001);
    tally_and_finish();
  end
endmodule : bdf_ctrl_test
`default_nettype wire
